// File: core/sp0_pkg.sv
// Package for the serial port 0 block: offsets, fields, types
`default_nettype none
package sp0_pkg;
   // Printed offsets are not all multiples of four: these are word indices
   localparam logic [7:0] CTRL_INDEX = 8'h98;
   localparam logic [7:0] DATA_INDEX = 8'h99;
   // Own registers for the surrounding logic, also as indices
   localparam logic [7:0] CFG_INDEX = 8'hA0;
   localparam logic [7:0] IRQ_STATUS_INDEX = 8'hA1;
   localparam logic [7:0] IRQ_MASK_INDEX = 8'hA2;
   localparam logic [7:0] BAUD_INDEX = 8'hA3;
   localparam int ADDR_W = 12;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Control field positions
   localparam int BIT_MODE_HI = 7;
   localparam int BIT_MODE_LO = 6;
   localparam int BIT_MP = 5;
   localparam int BIT_RX_EN = 4;
   localparam int BIT_TX9 = 3;
   localparam int BIT_RX9 = 2;
   localparam int BIT_TX_DONE = 1;
   localparam int BIT_RX_DONE = 0;
   // Config register fields
   localparam int BIT_FE_SEL = 0;
   localparam int BIT_BAUD_SRC = 1;
   // Interrupt status / mask bits
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_FE = 2;
   // Default period divisors, in system clocks per bit
   localparam logic [15:0] PM_DIV_RESET = 16'h000C;
   localparam logic [15:0] T1_DIV_RESET = 16'h006C;
   localparam logic [15:0] T2_DIV_RESET = 16'h0036;
   localparam int OVERSAMPLE = 16;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      SP0_MODE0, SP0_MODE1, SP0_MODE2, SP0_MODE3
   } sp0_mode_t;
   typedef enum {SP0_TX_IDLE, SP0_TX_SHIFT} sp0_tx_state_t;
   typedef enum {SP0_RX_IDLE, SP0_RX_START, SP0_RX_BITS,
      SP0_RX_SYNC} sp0_rx_state_t;
   typedef struct packed {
      logic mode_select_hi;
      logic mode_select_lo;
      logic multiprocessor_control;
      logic rx_enable;
      logic ninth_transmit_bit;
      logic ninth_received_bit;
      logic transmit_done_flag;
      logic receive_done_flag;
   } sp0_ctrl_t;
   typedef struct packed {
      logic txd;
      logic sclk;
      logic rxd_out;
      logic rxd_oe;
   } sp0_pins_t;
endpackage
`default_nettype wire

// File: core/sp0_serial_port.sv
// Serial port 0: shift mode and three async modes, AXI4-Lite registers
//
// Behaviour
// - Top control bits pick mode: 00 sync shift, 01/10/11 async modes 1-3.
// - Frame is 8 bits in mode 0, 10 in mode 1, 11 in modes 2/3.
// - Modes 1/3 use timer baud period; modes 0/2 use power-management period.
// - In mode 0 the multiprocessor bit picks one of two shift periods.
// - With frame-error select set, top bit is a sticky framing error flag.
// - Mode bit and error flag stored apart; writes then touch only the flag.
// - Mode 1 with multiprocessor bit: bad stop bit frame is dropped, but the framing error is still flagged.
// - Modes 2/3 with multiprocessor bit: no receive flag unless ninth bit 1.
// - Receive enable off blocks reception; in mode 0 it starts a shift-in.
// - Modes 2/3 send the ninth-transmit bit as ninth data bit.
// - Ninth-received bit holds ninth bit, or mode 1 stop bit if mp clear.
// - Transmit-done set after last data bit; only software clears it.
// - Receive-done set at end of frame per mode; software clears it.
// - Data address: writes load transmit buffer, reads give receive buffer.
//
// The AXI4-Lite slave port was left to the implementer.
`default_nettype none
module sp0_serial_port #(
   parameter int OVS = sp0_pkg::OVERSAMPLE
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sp0_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sp0_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rxd_in,
   output sp0_pkg::sp0_pins_t pins,
   output logic irq
);
   sp0_pkg::sp0_ctrl_t ctrl;
   logic frame_error_flag;
   logic [7:0] cfg;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [15:0] pm_div, t1_div, t2_div;
   logic [7:0] tx_buffer, rx_buffer;
   logic [7:0] aw_index;
   logic aw_held, w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   sp0_pkg::sp0_mode_t mode;
   logic wr_fire, wr_ctrl, wr_data, wr_status;
   logic set_tx_done, set_rx_done, set_fe;
   logic [7:0] rx_shift_byte;
   logic rx_ninth;
   logic [15:0] bit_div;

   assign mode = sp0_pkg::sp0_mode_t'({ctrl.mode_select_hi,
      ctrl.mode_select_lo});

   always_comb begin
      unique case (mode)
         sp0_pkg::SP0_MODE0: begin
            bit_div = ctrl.multiprocessor_control ? pm_div : {pm_div[13:0], 2'b00};
         end
         sp0_pkg::SP0_MODE2: bit_div = pm_div;
         default: bit_div = cfg[sp0_pkg::BIT_BAUD_SRC] ? t2_div : t1_div;
      endcase
   end

   // Bus: address and data latched in either order
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_ctrl = wr_fire && aw_index == sp0_pkg::CTRL_INDEX && w_strb[0];
   assign wr_data = wr_fire && aw_index == sp0_pkg::DATA_INDEX && w_strb[0];
   assign wr_status = wr_fire && aw_index == sp0_pkg::IRQ_STATUS_INDEX
      && w_strb[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_index <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sp0_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_index <= s_axi_awaddr[9:2];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_index)
               sp0_pkg::CTRL_INDEX, sp0_pkg::DATA_INDEX, sp0_pkg::CFG_INDEX,
               sp0_pkg::IRQ_STATUS_INDEX, sp0_pkg::IRQ_MASK_INDEX,
               sp0_pkg::BAUD_INDEX: s_axi_bresp <= sp0_pkg::RESP_OKAY;
               default: s_axi_bresp <= sp0_pkg::RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= sp0_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= sp0_pkg::RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         unique case (s_axi_araddr[9:2])
            sp0_pkg::CTRL_INDEX: begin
               s_axi_rdata[7:0] <= {cfg[sp0_pkg::BIT_FE_SEL] ?
                  frame_error_flag : ctrl.mode_select_hi, ctrl[6:0]};
            end
            sp0_pkg::DATA_INDEX: s_axi_rdata[7:0] <= rx_buffer;
            sp0_pkg::CFG_INDEX: s_axi_rdata[7:0] <= cfg;
            sp0_pkg::IRQ_STATUS_INDEX: s_axi_rdata[2:0] <= irq_status;
            sp0_pkg::IRQ_MASK_INDEX: s_axi_rdata[2:0] <= irq_mask;
            sp0_pkg::BAUD_INDEX: s_axi_rdata <= {t2_div, t1_div};
            default: s_axi_rresp <= sp0_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Config: frame-error select, timer choice, period divisors
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= 8'h00;
         irq_mask <= 3'b000;
         pm_div <= sp0_pkg::PM_DIV_RESET;
         t1_div <= sp0_pkg::T1_DIV_RESET;
         t2_div <= sp0_pkg::T2_DIV_RESET;
      end else if (wr_fire) begin
         if (aw_index == sp0_pkg::CFG_INDEX && w_strb[0]) begin
            cfg <= w_data[7:0];
         end
         if (aw_index == sp0_pkg::CFG_INDEX && w_strb[3:2] == 2'b11) begin
            pm_div <= w_data[31:16];
         end
         if (aw_index == sp0_pkg::IRQ_MASK_INDEX && w_strb[0]) begin
            irq_mask <= w_data[2:0];
         end
         if (aw_index == sp0_pkg::BAUD_INDEX) begin
            if (w_strb[1:0] == 2'b11) t1_div <= w_data[15:0];
            if (w_strb[3:2] == 2'b11) t2_div <= w_data[31:16];
         end
      end
   end

   // Control register; hardware set wins over software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= sp0_pkg::CTRL_RESET;
         frame_error_flag <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            if (cfg[sp0_pkg::BIT_FE_SEL])
               frame_error_flag <= w_data[sp0_pkg::BIT_MODE_HI];
            else
               ctrl.mode_select_hi <= w_data[sp0_pkg::BIT_MODE_HI];
            ctrl[6:0] <= w_data[6:0];
         end
         if (set_fe && cfg[sp0_pkg::BIT_FE_SEL]) frame_error_flag <= 1'b1;
         if (set_tx_done) ctrl.transmit_done_flag <= 1'b1;
         if (set_rx_done) begin
            ctrl.receive_done_flag <= 1'b1;
            if (mode != sp0_pkg::SP0_MODE0) ctrl.ninth_received_bit <= rx_ninth;
         end
      end
   end

   // Interrupt status, write one to clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 3'b000;
         irq <= 1'b0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (wr_status && w_data[i]) irq_status[i] <= 1'b0;
         end
         if (set_tx_done) irq_status[sp0_pkg::IRQ_TX] <= 1'b1;
         if (set_rx_done) irq_status[sp0_pkg::IRQ_RX] <= 1'b1;
         if (set_fe) irq_status[sp0_pkg::IRQ_FE] <= 1'b1;
         irq <= |(irq_status & irq_mask);
      end
   end

   // Transmitter
   sp0_pkg::sp0_tx_state_t tx_state;
   logic [10:0] tx_shift;
   logic [3:0] tx_left;
   logic [15:0] tx_cnt;
   logic tx_half;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state <= sp0_pkg::SP0_TX_IDLE;
         tx_buffer <= sp0_pkg::DATA_RESET;
         tx_shift <= 11'h7FF;
         tx_left <= 4'h0;
         tx_cnt <= 16'h0000;
         tx_half <= 1'b0;
         set_tx_done <= 1'b0;
         pins.txd <= 1'b1;
         pins.sclk <= 1'b1;
      end else begin
         set_tx_done <= 1'b0;
         unique case (tx_state)
            sp0_pkg::SP0_TX_IDLE: begin
               pins.txd <= 1'b1;
               pins.sclk <= 1'b1;
               if (wr_data) begin
                  tx_buffer <= w_data[7:0];
                  tx_cnt <= 16'h0000;
                  tx_half <= 1'b0;
                  tx_state <= sp0_pkg::SP0_TX_SHIFT;
                  unique case (mode)
                     sp0_pkg::SP0_MODE0: begin
                        tx_shift <= {3'b111, w_data[7:0]};
                        tx_left <= 4'd8;
                     end
                     sp0_pkg::SP0_MODE1: begin
                        tx_shift <= {1'b1, 1'b1, w_data[7:0], 1'b0};
                        tx_left <= 4'd10;
                     end
                     default: begin
                        tx_shift <= {1'b1, ctrl.ninth_transmit_bit,
                           w_data[7:0], 1'b0};
                        tx_left <= 4'd11;
                     end
                  endcase
               end
            end
            sp0_pkg::SP0_TX_SHIFT: begin
               if (mode == sp0_pkg::SP0_MODE0) pins.txd <= tx_shift[0];
               else pins.txd <= tx_shift[0];
               if (tx_cnt >= bit_div - 16'h0001) begin
                  tx_cnt <= 16'h0000;
                  tx_shift <= {1'b1, tx_shift[10:1]};
                  tx_left <= tx_left - 4'd1;
                  if ((mode == sp0_pkg::SP0_MODE0 && tx_left == 4'd1) ||
                      (mode != sp0_pkg::SP0_MODE0 && tx_left == 4'd2))
                     set_tx_done <= 1'b1;
                  if (tx_left == 4'd1) tx_state <= sp0_pkg::SP0_TX_IDLE;
               end else begin
                  tx_cnt <= tx_cnt + 16'h0001;
               end
               // Shift clock low in first half of each bit
               pins.sclk <= (mode != sp0_pkg::SP0_MODE0) ||
                  (tx_cnt >= {1'b0, bit_div[15:1]});
            end
         endcase
      end
   end

   // Receiver: whole-clock bit timing, a coarse tick would drift
   sp0_pkg::sp0_rx_state_t rx_state;
   logic [9:0] rx_bits;
   logic [3:0] rx_need, rx_got;
   logic [15:0] rx_cnt;
   logic rx_en_d;

   assign rx_shift_byte = (mode == sp0_pkg::SP0_MODE0) ? rx_bits[9:2] :
      rx_bits[7:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state <= sp0_pkg::SP0_RX_IDLE;
         rx_bits <= 10'h000;
         rx_need <= 4'h0;
         rx_got <= 4'h0;
         rx_cnt <= 16'h0000;
         rx_en_d <= 1'b0;
         rx_buffer <= sp0_pkg::DATA_RESET;
         rx_ninth <= 1'b0;
         set_rx_done <= 1'b0;
         set_fe <= 1'b0;
         pins.rxd_out <= 1'b1;
         pins.rxd_oe <= 1'b0;
      end else begin
         set_rx_done <= 1'b0;
         set_fe <= 1'b0;
         rx_en_d <= ctrl.rx_enable;
         unique case (rx_state)
            sp0_pkg::SP0_RX_IDLE: begin
               rx_cnt <= 16'h0000;
               rx_got <= 4'h0;
               if (ctrl.rx_enable && mode == sp0_pkg::SP0_MODE0 && !rx_en_d)
                  rx_state <= sp0_pkg::SP0_RX_SYNC;
               else if (ctrl.rx_enable && mode != sp0_pkg::SP0_MODE0
                        && !rxd_in) begin
                  rx_state <= sp0_pkg::SP0_RX_START;
                  rx_need <= (mode == sp0_pkg::SP0_MODE1) ? 4'd9 : 4'd10;
               end
            end
            sp0_pkg::SP0_RX_START, sp0_pkg::SP0_RX_BITS: begin
               if (!ctrl.rx_enable) rx_state <= sp0_pkg::SP0_RX_IDLE;
               else if (rx_cnt >= ((rx_state == sp0_pkg::SP0_RX_START) ?
                        {1'b0, bit_div[15:1]} : bit_div) - 16'h0001) begin
                  rx_cnt <= 16'h0000;
                  // Start checked at half bit, then one sample per bit
                  if (rx_state == sp0_pkg::SP0_RX_START) begin
                     if (rxd_in) rx_state <= sp0_pkg::SP0_RX_IDLE;
                     else rx_state <= sp0_pkg::SP0_RX_BITS;
                  end else begin
                     rx_bits <= {rxd_in, rx_bits[9:1]};
                     rx_got <= rx_got + 4'd1;
                     if (rx_got + 4'd1 == rx_need) begin
                        rx_state <= sp0_pkg::SP0_RX_IDLE;
                        if (mode == sp0_pkg::SP0_MODE1) begin
                           set_fe <= !rxd_in;
                           if (!(ctrl.multiprocessor_control && !rxd_in)) begin
                              set_rx_done <= 1'b1;
                              rx_buffer <= rx_bits[9:2];
                              rx_ninth <= rxd_in;
                           end
                        end else begin
                           set_fe <= !rxd_in;
                           if (!ctrl.multiprocessor_control || rx_bits[9]) begin
                              set_rx_done <= 1'b1;
                              rx_buffer <= rx_bits[8:1];
                              rx_ninth <= rx_bits[9];
                           end
                        end
                     end
                  end
               end else begin
                  rx_cnt <= rx_cnt + 16'h0001;
               end
            end
            sp0_pkg::SP0_RX_SYNC: begin
               // Mode 0 shift-in: sample data at the end of each bit period
               if (rx_cnt >= bit_div - 16'h0001) begin
                  rx_cnt <= 16'h0000;
                  rx_bits <= {rxd_in, rx_bits[9:1]};
                  rx_got <= rx_got + 4'd1;
                  if (rx_got == 4'd7) begin
                     rx_state <= sp0_pkg::SP0_RX_IDLE;
                     set_rx_done <= 1'b1;
                     rx_buffer <= {rxd_in, rx_bits[9:3]};
                  end
               end else begin
                  rx_cnt <= rx_cnt + 16'h0001;
               end
            end
         endcase
      end
   end
endmodule // sp0_serial_port
`default_nettype wire

// File: verif/sp0_serial_port_sva.sv
// Checker for the serial port's bus answers, reset state and reserved pins
`default_nettype none
module sp0_serial_port_sva #(
   parameter int OVS = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rxd_in,
   input wire sp0_pkg::sp0_pins_t pins,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wire logic [7:0] ri = s_axi_araddr[9:2];
   wire logic known = ri inside {8'h98, 8'h99, 8'hA0, 8'hA1, 8'hA2, 8'hA3};
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   reset_idle_a: assert property (disable iff (1'b0)
      !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && pins.txd && pins.sclk
      && !irq) else $error("outputs not idle after reset");
   b_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid)
      else $error("no write response after take");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   r_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("no read data after take");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   busy_refuse_a: assert property (s_axi_bvalid || s_axi_rvalid |->
      !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready))
      else $error("request taken while answer pending");
   unmapped_a: assert property (rd_taken ##0 !known |=>
      s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   byte_regs_a: assert property (rd_taken ##0 ri[7:1] == 7'h4C |=>
      s_axi_rresp == 2'b00 && s_axi_rdata[31:8] == 24'h00_0000)
      else $error("byte register read malformed");
   pins_reserved_a: assert property (!pins.rxd_oe && pins.rxd_out)
      else $error("reserved pin driven");
   cover property (rd_taken ##0 !known);
endmodule // sp0_serial_port_sva
bind sp0_serial_port sp0_serial_port_sva #(.OVS(OVS)) chk_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .rxd_in(rxd_in), .pins(pins), .irq(irq));
`default_nettype wire

// File: verif/sp0_peer.sv
// Remote serial node: drives frames onto the port's receive line
`default_nettype none
module sp0_peer (
   input wire logic aclk,
   output var logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line = 1'b1;
   task automatic send(input logic [10:0] f, input int n, input int p);
      for (int i = 0; i < n; i++) begin
         line <= f[i];
         repeat (p) @(posedge aclk);
      end
      // Line rests at mark level between frames
      line <= 1'b1;
   endtask
endmodule // sp0_peer
`default_nettype wire

// File: verif/tb_sp0_serial_port.sv
// Bench for serial port 0: registers, transmit, receive, interrupt
`default_nettype none
module tb_sp0_serial_port;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CI = sp0_pkg::CTRL_INDEX;
   localparam logic [7:0] DI = sp0_pkg::DATA_INDEX;
   localparam logic [7:0] FI = sp0_pkg::CFG_INDEX;
   localparam logic [7:0] SI = sp0_pkg::IRQ_STATUS_INDEX;
   localparam logic [7:0] MI = sp0_pkg::IRQ_MASK_INDEX;
   localparam int T1 = 108;
   localparam int PM = 12;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd;
   logic [3:0] wstrb = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, rxd;
   logic [1:0] bresp, rresp, wrsp, rsp;
   logic [7:0] b;
   logic [10:0] cap;
   sp0_pkg::sp0_pins_t pins;
   int error_cnt = 0, checks_done = 0, seed = 3, k;
   int md[6] = '{0, 0, 1, 2, 3, 3};
   int mp[6] = '{0, 1, 0, 0, 0, 0};
   int b9[6] = '{0, 0, 0, 0, 1, 0};
   int t2[6] = '{0, 0, 0, 0, 0, 1};
   int per[6] = '{48, 12, 108, 12, 108, 54};
   sp0_serial_port dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .rxd_in(rxd), .pins(pins), .irq(irq));
   sp0_peer peer_u (.aclk(aclk), .line(rxd));
   initial forever #2.5 aclk = ~aclk;
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] g, e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t reg got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_frame(input logic [10:0] g, e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t frame got %b exp %b", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic a, w;
      @(posedge aclk);
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= d;
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      a = 1'b1;
      w = 1'b1;
      while (a || w) begin
         @(posedge aclk);
         if (awready === 1'b1) a = 1'b0;
         if (wready === 1'b1) w = 1'b0;
         awvalid <= a;
         wvalid <= w;
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      wrsp = bresp;
   endtask
   task automatic rd_reg(input logic [7:0] idx);
      @(posedge aclk);
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd = rdata;
      rsp = rresp;
   endtask
   function automatic logic [10:0] frame(input int m, input logic [7:0] d,
         input logic n9);
      if (m == 0) return {3'b111, d};
      if (m == 1) return {2'b11, d, 1'b0};
      return {1'b1, n9, d, 1'b0};
   endfunction
   function automatic logic [31:0] cfg(input logic fe, input logic ts);
      return {16'h000C, 14'h0000, ts, fe};
   endfunction
   // Samples the pin a quarter into each bit after the first falling edge
   task automatic grab(input int n, input int p, input logic s);
      cap = '1;
      do @(posedge aclk); while ((s ? pins.sclk : pins.txd) !== 1'b0);
      repeat (p / 4) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         cap[i] = pins.txd;
         repeat (p) @(posedge aclk);
      end
   endtask
   task automatic rx_test(input logic [7:0] c, input int m, input logic n9,
         input logic bad, input int p, input logic [7:0] e, m8);
      logic [10:0] f;
      wr(CI, 32'(c));
      b = $random(seed);
      f = frame(m, b, n9);
      if (bad) f[m == 1 ? 9 : 10] = 1'b0;
      @(posedge aclk);
      peer_u.send(f, m == 1 ? 10 : 11, p);
      repeat (p) @(posedge aclk);
      rd_reg(CI);
      chk_reg(rd & 32'(m8), 32'(e & m8));
      if (e[0]) begin
         rd_reg(DI);
         chk_reg(rd, 32'(b));
      end
   endtask
   initial begin
      logic [7:0] c;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(CI);
      chk_reg(rd, 32'h0000_0000);
      rd_reg(DI);
      chk_reg(rd, 32'h0000_0000);
      rd_reg(8'h50);
      chk_reg(32'(rsp), 32'h0000_0002);
      wr(8'h50, 32'h0000_00FF);
      chk_reg(32'(wrsp), 32'h0000_0002);
      for (int i = 0; i < 6; i++) begin
         c = {md[i][1:0], mp[i][0], 1'b0, b9[i][0], 3'b000};
         wr(FI, cfg(1'b0, t2[i][0]));
         wr(CI, 32'(c));
         b = $random(seed);
         fork
            wr(DI, 32'(b));
            grab(md[i] == 0 ? 8 : md[i] == 1 ? 10 : 11, per[i], md[i] == 0);
         join
         chk_frame(cap, frame(md[i], b, b9[i][0]));
         k = 0;
         do begin
            rd_reg(CI);
            k++;
         end while (rd[1] !== 1'b1 && k < 60);
         chk_reg(rd, 32'(c | 8'h02));
         rd_reg(SI);
         chk_reg(rd & 32'h0000_0001, 32'h0000_0001);
         wr(SI, 32'h0000_0007);
      end
      wr(FI, cfg(1'b0, 1'b0));
      rx_test(8'h40, 1, 1'b0, 1'b0, T1, 8'h40, 8'hFF);
      rd_reg(DI);
      chk_reg(rd, 32'h0000_0000);
      wr(MI, 32'h0000_0002);
      rx_test(8'h50, 1, 1'b0, 1'b0, T1, 8'h55, 8'hFF);
      chk_reg(32'(irq), 32'h0000_0001);
      wr(SI, 32'h0000_0007);
      repeat (2) @(posedge aclk);
      chk_reg(32'(irq), 32'h0000_0000);
      wr(MI, 32'h0000_0000);
      rx_test(8'h70, 1, 1'b0, 1'b1, T1, 8'h70, 8'hFF);
      rx_test(8'hB0, 2, 1'b0, 1'b0, PM, 8'hB0, 8'hFB);
      rx_test(8'hB0, 2, 1'b1, 1'b0, PM, 8'hB5, 8'hFF);
      rd_reg(SI);
      chk_reg(rd & 32'h0000_0002, 32'h0000_0002);
      chk_reg(32'(irq), 32'h0000_0000);
      rx_test(8'hD0, 3, 1'b0, 1'b0, T1, 8'hD1, 8'hFF);
      wr(FI, cfg(1'b1, 1'b0));
      rd_reg(CI);
      chk_reg(rd, 32'h0000_0051);
      wr(CI, 32'h0000_0050);
      wr(FI, cfg(1'b0, 1'b0));
      rd_reg(CI);
      chk_reg(rd, 32'h0000_00D0);
      wr(CI, 32'h0000_0050);
      wr(FI, cfg(1'b1, 1'b0));
      rx_test(8'h50, 1, 1'b0, 1'b1, T1, 8'hD1, 8'hFF);
      rd_reg(SI);
      chk_reg(rd & 32'h0000_0004, 32'h0000_0004);
      wr(CI, 32'h0000_0050);
      rd_reg(CI);
      chk_reg(rd, 32'h0000_0050);
      print_verdict();
   end
   initial begin
      repeat (60000) @(posedge aclk);
      error_cnt++;
      print_verdict();
   end
endmodule // tb_sp0_serial_port
`default_nettype wire
